// file: bench/ans_eng_model.sv
// Purpose: stand-in for the negotiation engine that delivers partner pages
// Assumes: one page request at a time, gap counts idle cycles before strobe
// Notes: outside the strobe the word lines flip every cycle
`timescale 1ns/100ps
module ans_eng_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [15:0] word_i,
    input wire logic tog_i,
    input wire logic [3:0] gap_i,
    output logic page_rx_stb_o,
    output logic [15:0] page_word_o,
    output logic last_tx_toggle_o,
    output logic busy_o
);
    logic [3:0] cnt_reg;
    logic [15:0] word_reg;
    logic tog_reg;

    // ************************************************************
    // page delivery, prompt or slow
    // ************************************************************
    // word lines carry nothing valid between strobes
    always_ff @(posedge clk_i) begin
        page_rx_stb_o <= 1'b0;
        page_word_o <= ~page_word_o;
        last_tx_toggle_o <= ~last_tx_toggle_o;
        if (rst_i) begin
            busy_o <= 1'b0;
            cnt_reg <= 4'h0;
            page_word_o <= 16'h0000;
            last_tx_toggle_o <= 1'b0;
        end else if (req_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt_reg <= gap_i;
            word_reg <= word_i;
            tog_reg <= tog_i;
        end else if (busy_o && cnt_reg == 4'h0) begin
            busy_o <= 1'b0;
            page_rx_stb_o <= 1'b1;
            page_word_o <= word_reg;
            last_tx_toggle_o <= tog_reg;
        end else if (busy_o) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule : ans_eng_model

// file: bench/ans_regs_tb_top.sv
// Purpose: self-checking bench for the partner status registers
// Assumes: classic wishbone master, engine model on the page side
// Notes: random pages from a fixed seed plus all-ones and zero words
`timescale 1ns/100ps
module ans_regs_tb_top;
    import ans_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq, req, tog, fault, lpnp, lpan;
    logic pstb, ptog, busy, ce;
    logic [7:0] adr;
    logic [3:0] sel, gap;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] word, pword;
    int seed = 75954;
    int err_total = 0;
    int comparisons = 0;

    always #2 clk_i = ~clk_i;

    ans_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .page_rx_stb_i(pstb), .page_word_i(pword),
        .last_tx_toggle_i(ptog), .pd_fault_i(fault),
        .partner_next_page_capable_i(lpnp),
        .partner_autoneg_capable_i(lpan), .irq_o(irq));

    ans_eng_model eng (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .word_i(word), .tog_i(tog), .gap_i(gap), .page_rx_stb_o(pstb),
        .page_word_o(pword), .last_tx_toggle_o(ptog), .busy_o(busy));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [5:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic send(input logic [15:0] w, input logic t,
                        input logic [3:0] g);
        int n;
        n = 0;
        @(posedge clk_i);
        word <= w;
        tog <= t;
        gap <= g;
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 40);
        repeat (2) @(posedge clk_i);
    endtask : send

    function automatic logic [31:0] np_exp(input logic [15:0] w,
                                           input logic t);
        return {16'h0, w[15:12], ~t, w[10:0]};
    endfunction : np_exp

    function automatic logic [31:0] ex_exp(input logic f);
        return {27'h0, fault, lpnp, 1'b1, f, lpan};
    endfunction : ex_exp

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        logic [15:0] w;
        logic t;
        {cyc, stb, we, req, tog, fault, lpnp, lpan} = 8'h00;
        ce = 1'b1;
        adr = 8'h00;
        sel = 4'hf;
        gap = 4'h0;
        wdat = 32'h0;
        word = 16'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, IDX_NP_WORD, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, IDX_EXP, 32'h0);
        chk(rd, 32'h4);
        $display("reset values done");
        bus(1'b1, IDX_IRQ_MASK, 32'h1);
        for (int i = 0; i < 8; i++) begin
            fault <= $random(seed);
            lpnp <= $random(seed);
            lpan <= $random(seed);
            w = (i == 6) ? 16'h0000 : (i == 7) ? 16'hffff : $random(seed);
            t = $random(seed);
            send(w, t, (i == 0) ? 4'h0 : 4'($random(seed)));
            chk({31'h0, irq}, 32'h1);
            bus(1'b0, IDX_NP_WORD, 32'h0);
            chk(rd, np_exp(w, t));
            bus(1'b1, IDX_NP_WORD, ~np_exp(w, t));
            bus(1'b0, IDX_NP_WORD, 32'h0);
            chk(rd, np_exp(w, t));
            bus(1'b0, IDX_EXP, 32'h0);
            chk(rd, ex_exp(1'b1));
            bus(1'b1, IDX_EXP, 32'hffffffff);
            bus(1'b0, IDX_EXP, 32'h0);
            chk(rd, ex_exp(1'b0));
            bus(1'b1, IDX_IRQ_ST, 32'h1);
            @(posedge clk_i);
            chk({31'h0, irq}, 32'h0);
        end
        $display("random pages done");
        fault <= 1'b0;
        bus(1'b1, IDX_IRQ_MASK, 32'h0);
        bus(1'b1, IDX_IRQ_ST, 32'h3);
        send(16'h2001, 1'b1, 4'h3);
        fault <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, IDX_IRQ_ST, 32'h0);
        chk(rd, 32'h3);
        bus(1'b1, IDX_IRQ_ST, 32'h3);
        bus(1'b0, IDX_IRQ_ST, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 6'h3f, 32'h0);
        chk(rd, 32'h0);
        // a page during low enable must be lost entirely
        ce <= 1'b0;
        send(16'h1234, 1'b0, 4'h0);
        ce <= 1'b1;
        bus(1'b0, IDX_NP_WORD, 32'h0);
        chk(rd, np_exp(16'h2001, 1'b1));
        bus(1'b0, IDX_IRQ_ST, 32'h0);
        chk(rd, 32'h0);
        $display("interrupt and unmapped done");
        conclude();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        conclude();
    end
endmodule : ans_regs_tb_top

// file: inc/ans_pkg.sv
// Purpose: constants for the auto-negotiation partner status registers
// Assumes: classic wishbone, 32-bit data, registers one word per index
// Notes: byte address of a register is four times its index
// How it works
// - bit 13 of the partner next-page word is 1 for a message page, 0 else.
// - bit 12 of that word shows whether the partner can comply, reset 0.
// - bit 11 reads 1 when the previous transmitted toggle was 0, else 0.
// - bits 10:0 of that word hold the received code field, reset zero.
// - with bit 13 set the code is a message code, else it is unformatted.
// - the expansion status register sits at management index 6.
// - expansion bits 15:5 read zero and writes to them do nothing.
// - expansion bit 4 shows a parallel detection fault, reset 0.
// - expansion bit 3 shows the partner supports next pages, reset 0.
// - expansion bit 2 reads a fixed 1, the local side can send next pages.
// - expansion bit 1 sets on a received page and clears when read.
// - expansion bit 0 shows the partner supports auto-negotiation.
// - the acknowledge bit follows received pages only, never software.
package ans_pkg;

    // ************************************************************
    // register indices, byte address is index times four
    // ************************************************************
    localparam logic [5:0] IDX_NP_WORD = 6'h05;
    localparam logic [5:0] IDX_EXP = 6'h06;
    localparam logic [5:0] IDX_IRQ_ST = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int NP_ACK_BIT = 14;
    localparam int NP_MSG_BIT = 13;
    localparam int NP_COMPLY_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;
    localparam int EXP_FAULT_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_LOCAL_NP_BIT = 2;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_AN_BIT = 0;
    localparam int EV_PAGE = 0;
    localparam int EV_FAULT = 1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] NP_WORD_RST = 16'h0000;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [15:0] EXP_FIXED = 16'h0004;

    // eight mask bits per byte lane of the low half-word
    function automatic logic [15:0] ans_lane_mask(input logic [3:0] sel);
        ans_lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : ans_lane_mask

endpackage : ans_pkg

// file: inc/ans_req_if.sv
// Purpose: carries decoded register requests between bus port and registers
// Assumes: strobes are one-cycle pulses
// Notes: read data returns in the same cycle
`timescale 1ns/100ps
interface ans_req_if;
    logic rd_stb;
    logic wr_stb;
    logic [5:0] idx;
    logic [31:0] wdata;
    logic [3:0] sel;
    logic [31:0] rdata;

    // bus side raises requests
    modport port (output rd_stb, output wr_stb, output idx, output wdata,
                  output sel, input rdata);
    // register side answers them
    modport regs (input rd_stb, input wr_stb, input idx, input wdata,
                  input sel, output rdata);
endinterface : ans_req_if

// file: verilog/ans_regs.sv
// Purpose: partner next-page word and expansion status registers
// Assumes: negotiation engine drives page strobe and ability levels
// Notes: interrupt status and mask sit beside the documented registers
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module ans_regs
    import ans_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic page_rx_stb_i,
    input wire logic [15:0] page_word_i,
    input wire logic last_tx_toggle_i,
    input wire logic pd_fault_i,
    input wire logic partner_next_page_capable_i,
    input wire logic partner_autoneg_capable_i,
    output logic irq_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    ans_req_if req ();

    logic [15:0] np_word_reg;
    logic [15:0] np_word_next;
    logic parallel_detect_fault_flag_reg;
    logic parallel_detect_fault_flag_next;
    logic partner_next_page_capable_reg;
    logic partner_next_page_capable_next;
    logic partner_autoneg_capable_reg;
    logic partner_autoneg_capable_next;
    logic page_rx_reg;
    logic page_rx_next;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_st_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    logic [15:0] exp_word;
    logic [15:0] wmask;
    logic exp_read;
    logic fault_rise;
    logic [1:0] events;

    // ************************************************************
    // bus front end
    // ************************************************************
    // wishbone slave, decoded requests come back through req
    ans_wb_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .req(req.port)
    );

    // ************************************************************
    // partner next-page word
    // ************************************************************
    // loaded only from a received page, bus writes never reach it
    always_comb begin
        np_word_next = np_word_reg;
        if (page_rx_stb_i) begin
            np_word_next = page_word_i;
            np_word_next[NP_TOGGLE_BIT] = ~last_tx_toggle_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            np_word_reg <= NP_WORD_RST;
        end else if (ce_i) begin
            np_word_reg <= np_word_next;
        end
    end

    // ************************************************************
    // expansion status flags
    // ************************************************************
    assign exp_read = req.rd_stb && (req.idx == IDX_EXP);

    // ability levels follow the engine, page flag is sticky
    always_comb begin
        parallel_detect_fault_flag_next = pd_fault_i;
        partner_next_page_capable_next = partner_next_page_capable_i;
        partner_autoneg_capable_next = partner_autoneg_capable_i;
        page_rx_next = page_rx_reg;
        if (exp_read) begin
            page_rx_next = 1'b0;
        end
        if (page_rx_stb_i) begin
            page_rx_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            parallel_detect_fault_flag_reg <= 1'b0;
            partner_next_page_capable_reg <= 1'b0;
            partner_autoneg_capable_reg <= 1'b0;
            page_rx_reg <= 1'b0;
        end else if (ce_i) begin
            parallel_detect_fault_flag_reg <= parallel_detect_fault_flag_next;
            partner_next_page_capable_reg <= partner_next_page_capable_next;
            partner_autoneg_capable_reg <= partner_autoneg_capable_next;
            page_rx_reg <= page_rx_next;
        end
    end

    // assemble expansion word, upper bits constant zero
    always_comb begin
        exp_word = EXP_FIXED;
        exp_word[EXP_FAULT_BIT] = parallel_detect_fault_flag_reg;
        exp_word[EXP_LP_NP_BIT] = partner_next_page_capable_reg;
        exp_word[EXP_PAGE_RX_BIT] = page_rx_reg;
        exp_word[EXP_LP_AN_BIT] = partner_autoneg_capable_reg;
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    assign fault_rise = pd_fault_i & ~parallel_detect_fault_flag_reg;
    assign events = {fault_rise, page_rx_stb_i};
    assign wmask = ans_lane_mask(req.sel);

    // write one clears, a new event wins over the clear
    always_comb begin
        irq_st_next = irq_st_reg;
        irq_mask_next = irq_mask_reg;
        if (req.wr_stb && (req.idx == IDX_IRQ_ST)) begin
            irq_st_next = irq_st_reg & ~(req.wdata[1:0] & wmask[1:0]);
        end
        if (req.wr_stb && (req.idx == IDX_IRQ_MASK)) begin
            irq_mask_next = (irq_mask_reg & ~wmask[1:0])
                | (req.wdata[1:0] & wmask[1:0]);
        end
        irq_st_next = irq_st_next | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_reg <= IRQ_RST;
            irq_mask_reg <= IRQ_RST;
        end else if (ce_i) begin
            irq_st_reg <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    assign irq_o = |(irq_st_reg & irq_mask_reg);

    // ************************************************************
    // read mux
    // ************************************************************
    // 16-bit words in the low half, unmapped reads give zero
    always_comb begin
        req.rdata = 32'h0000_0000;
        unique case (req.idx)
            IDX_NP_WORD: req.rdata[15:0] = np_word_reg;
            IDX_EXP: req.rdata[15:0] = exp_word;
            IDX_IRQ_ST: req.rdata[1:0] = irq_st_reg;
            IDX_IRQ_MASK: req.rdata[1:0] = irq_mask_reg;
            default: req.rdata = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    msg_page_a: assert property (
        page_rx_stb_i && ce_i |=>
            np_word_reg[NP_MSG_BIT] == $past(page_word_i[NP_MSG_BIT]))
        else $error("message page bit not captured");

    comply_bit_a: assert property (
        page_rx_stb_i && ce_i |=>
            np_word_reg[NP_COMPLY_BIT] == $past(page_word_i[NP_COMPLY_BIT]))
        else $error("comply bit not captured");

    toggle_bit_a: assert property (
        page_rx_stb_i && ce_i |=>
            np_word_reg[NP_TOGGLE_BIT] != $past(last_tx_toggle_i))
        else $error("toggle bit not inverted");

    code_field_a: assert property (
        page_rx_stb_i && ce_i |=> np_word_reg[10:0] == $past(page_word_i[10:0]))
        else $error("code field not captured");

    code_read_a: assert property (
        req.rd_stb && req.idx == IDX_NP_WORD && !page_rx_stb_i |=>
            wb_ack_o && wb_dat_o[15:0] == np_word_reg)
        else $error("next-page word read wrong");

    exp_addr_a: assert property (
        req.rd_stb && req.idx == IDX_EXP |=> wb_ack_o && wb_dat_o[2])
        else $error("expansion register not at index 6");

    exp_reserved_a: assert property (
        req.rd_stb && req.idx == IDX_EXP |=> wb_dat_o[31:5] == 27'h0)
        else $error("reserved expansion bits not zero");

    fault_track_a: assert property (
        ce_i |=> parallel_detect_fault_flag_reg == $past(pd_fault_i))
        else $error("fault flag not following engine");

    partner_np_a: assert property (
        ce_i ##1 ce_i |=> exp_word[EXP_LP_NP_BIT]
            == $past(partner_next_page_capable_i))
        else $error("partner next page flag wrong");

    local_np_a: assert property (
        exp_word[EXP_LOCAL_NP_BIT] && req.rdata[31:16] == 16'h0000)
        else $error("local next page flag not fixed");

    page_clear_a: assert property (
        exp_read && !page_rx_stb_i |=>
            !page_rx_reg ##1 (!wb_ack_o || !$past(ce_i)))
        else $error("page flag not cleared on read");

    page_set_a: assert property (
        page_rx_stb_i && ce_i |=> page_rx_reg && irq_st_reg[EV_PAGE])
        else $error("page event lost");

    lp_an_a: assert property (
        ce_i |=> partner_autoneg_capable_reg
            == $past(partner_autoneg_capable_i))
        else $error("partner autoneg flag wrong");

    ack_hold_a: assert property (
        !page_rx_stb_i |=> $stable(np_word_reg[NP_ACK_BIT]))
        else $error("acknowledge bit changed without a page");

    wb_ack_a: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=>
            wb_ack_o ##1 (!wb_ack_o || !$past(ce_i)))
        else $error("ack timing wrong");

    // bus writes never reach the received word
    np_write_a: assert property (
        req.wr_stb && !page_rx_stb_i |=> $stable(np_word_reg))
        else $error("bus write reached next-page word");

    // low enable holds every register and the answer
    ce_hold_a: assert property (
        !ce_i |=> $stable(np_word_reg) && $stable(irq_st_reg)
            && $stable(page_rx_reg) && $stable(wb_ack_o))
        else $error("state moved while clock enable low");

    unmapped_rd_a: assert property (
        req.rd_stb && req.idx != IDX_NP_WORD && req.idx != IDX_EXP
            && req.idx != IDX_IRQ_ST && req.idx != IDX_IRQ_MASK
            |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    upper_zero_a: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper half of read data not zero");

    // rising fault is latched as an interrupt event
    fault_event_a: assert property (
        ce_i && pd_fault_i && !parallel_detect_fault_flag_reg |=>
            irq_st_reg[EV_FAULT])
        else $error("fault event not latched");

    page_irq_clr_a: assert property (
        req.wr_stb && req.idx == IDX_IRQ_ST && req.wdata[EV_PAGE]
            && req.sel[0] && !page_rx_stb_i |=> !irq_st_reg[EV_PAGE])
        else $error("page status not cleared by write");

    mask_write_a: assert property (
        req.wr_stb && req.idx == IDX_IRQ_MASK && req.sel[0] |=>
            irq_mask_reg == $past(req.wdata[1:0]))
        else $error("mask write lost");

    irq_page_a: assert property (
        page_rx_stb_i && ce_i && irq_mask_reg[EV_PAGE]
            && !(req.wr_stb && req.idx == IDX_IRQ_MASK) |=> irq_o)
        else $error("interrupt not raised on page");

endmodule : ans_regs

// file: verilog/ans_wb_port.sv
// Purpose: classic wishbone slave front end for the status registers
// Assumes: one request at a time, master holds it until ack
// Notes: ack one cycle after the request, dropped the cycle after
`timescale 1ns/100ps
module ans_wb_port
    import ans_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ans_req_if.port req
);

    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic take;

    // ************************************************************
    // request decode
    // ************************************************************
    // a request is taken once, in the cycle before ack
    assign take = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg;
    assign req.rd_stb = take & ~wb_we_i;
    assign req.wr_stb = take & wb_we_i;
    assign req.idx = wb_adr_i[7:2];
    assign req.wdata = wb_dat_i;
    assign req.sel = wb_sel_i;

    // ************************************************************
    // answer
    // ************************************************************
    // next ack and registered read data
    always_comb begin
        ack_next = take;
        dat_next = dat_reg;
        if (take && !wb_we_i) begin
            dat_next = req.rdata;
        end
    end

    // register answer, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

endmodule : ans_wb_port
